// ---- rtl/asr_pkg.sv ----
// Constants and types for the asynchronous byte memory controller
package asr_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_READ_CYCLE_NS = 150;
  localparam int unsigned T_OE_ACCESS_NS = 70;
  localparam int unsigned T_ADDR_TO_END_NS = 100;
  localparam int unsigned T_DATA_TO_END_NS = 60;
  localparam int unsigned T_SEL_TO_END_NS = 100;
  localparam int unsigned T_FLOAT_NS = 50;
  localparam int unsigned READ_CYC = (T_READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SEL_CYC = (T_SEL_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DATA_CYC = (T_DATA_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FLOAT_CYC = (T_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 5;
  typedef enum logic [2:0] {
    ASR_IDLE = 3'b000,
    ASR_SETUP = 3'b001,
    ASR_ACCESS = 3'b011,
    ASR_END = 3'b010,
    ASR_RECOVER = 3'b110,
    ASR_RETAIN = 3'b111
  } asr_state_t;
endpackage

// ---- rtl/asr_ctrl.sv ----
// Host-side controller for an asynchronous 8K x 8 static memory
`timescale 1ns/1ns
`default_nettype none
module asr_ctrl
  import asr_pkg::*;
#(
  parameter int unsigned ADDR_W = 13,
  parameter int unsigned DATA_W = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic retain_req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic retain_ok,
  output logic [ADDR_W-1:0] address_lines,
  output logic chip_select_low_n,
  output logic chip_select_high,
  output logic output_strobe_n,
  output logic write_strobe_n,
  input wire logic [DATA_W-1:0] data_pins_in,
  output logic [DATA_W-1:0] data_pins_out,
  output logic data_pins_oe_n
);
  // Elaboration checks: pin widths and counter width must suit the timing set
  if (ADDR_W != 13) begin : g_chk_addr
    $error("asr_ctrl serves only 13 address bits");
  end
  if (DATA_W != 8) begin : g_chk_data
    $error("asr_ctrl serves only 8 data bits");
  end
  if (READ_CYC > (1 << CNT_W)) begin : g_chk_cnt_rd
    $error("cycle counter too narrow for the read window");
  end
  if (SEL_CYC > (1 << CNT_W)) begin : g_chk_cnt_wr
    $error("cycle counter too narrow for the write window");
  end

  typedef struct packed {
    asr_state_t state;
    logic [CNT_W-1:0] cnt;
    logic is_write;
    logic req_ready;
    logic rsp_valid;
    logic [DATA_W-1:0] rsp_rdata;
    logic retain_ok;
    logic [ADDR_W-1:0] address_lines;
    logic chip_select_low_n;
    logic chip_select_high;
    logic output_strobe_n;
    logic write_strobe_n;
    logic [DATA_W-1:0] data_pins_out;
    logic data_pins_oe_n;
    logic [DATA_W-1:0] wdata;
  } asr_regs_t;

  // Pins idle deselected with both strobes high and the bus released
  localparam asr_regs_t RESET_VAL = '{
    state: ASR_IDLE,
    cnt: '0,
    is_write: 1'b0,
    req_ready: 1'b0,
    rsp_valid: 1'b0,
    rsp_rdata: '0,
    retain_ok: 1'b0,
    address_lines: '0,
    chip_select_low_n: 1'b1,
    chip_select_high: 1'b0,
    output_strobe_n: 1'b1,
    write_strobe_n: 1'b1,
    data_pins_out: '0,
    data_pins_oe_n: 1'b1,
    wdata: '0
  };

  asr_regs_t r;
  asr_regs_t next_r;

  // A request is taken only when ready was shown on the previous edge
  logic take;
  assign take = req_valid && r.req_ready && !retain_req;

  always_comb begin
    next_r = r;
    next_r.rsp_valid = 1'b0;
    next_r.req_ready = 1'b0;
    case (r.state)
      ASR_IDLE: begin
        next_r.req_ready = !retain_req;
        if (retain_req) begin
          // Deselect first; supply may drop only after this
          next_r.chip_select_low_n = 1'b1;
          next_r.chip_select_high = 1'b0;
          next_r.state = ASR_RETAIN;
        end else if (take) begin
          // Address moves only while the write strobe is high
          next_r.address_lines = req_addr;
          next_r.is_write = req_write;
          // Write data held from the take so the host may move on
          next_r.wdata = req_wdata;
          next_r.write_strobe_n = 1'b1;
          next_r.req_ready = 1'b0;
          next_r.cnt = '0;
          next_r.state = ASR_SETUP;
        end
      end

      ASR_SETUP: begin
        // Selects open the cycle; the write begins on the last of them
        next_r.chip_select_low_n = 1'b0;
        next_r.chip_select_high = 1'b1;
        if (r.is_write) begin
          // Strobe falls with selects so the device never drives
          next_r.write_strobe_n = 1'b0;
          next_r.output_strobe_n = 1'b1;
          next_r.cnt = CNT_W'(SEL_CYC - 1);
        end else begin
          next_r.output_strobe_n = 1'b0;
          next_r.cnt = CNT_W'(READ_CYC - 1);
        end
        next_r.state = ASR_ACCESS;
      end

      ASR_ACCESS: begin
        // Data driven only after the device output has floated
        if (r.is_write && r.cnt == CNT_W'(SEL_CYC - FLOAT_CYC)) begin
          next_r.data_pins_out = r.wdata;
          next_r.data_pins_oe_n = 1'b0;
        end
        if (r.cnt == '0) begin
          next_r.state = ASR_END;
        end else begin
          next_r.cnt = r.cnt - CNT_W'(1);
        end
      end

      ASR_END: begin
        // Write strobe rises first and ends the write; data captured
        next_r.write_strobe_n = 1'b1;
        if (!r.is_write) begin
          next_r.rsp_rdata = data_pins_in;
          next_r.rsp_valid = 1'b1;
          next_r.output_strobe_n = 1'b1;
        end
        next_r.state = ASR_RECOVER;
      end

      ASR_RECOVER: begin
        // Zero hold: release data and selects one cycle later
        next_r.data_pins_oe_n = 1'b1;
        next_r.chip_select_low_n = 1'b1;
        next_r.chip_select_high = 1'b0;
        next_r.output_strobe_n = 1'b1;
        next_r.write_strobe_n = 1'b1;
        next_r.rsp_valid = r.is_write;
        next_r.state = ASR_IDLE;
      end

      ASR_RETAIN: begin
        // Selects stay off for one read cycle time after the supply returns
        next_r.retain_ok = retain_req;
        if (retain_req) begin
          next_r.cnt = CNT_W'(READ_CYC - 1);
        end else if (r.cnt == '0) begin
          next_r.state = ASR_IDLE;
        end else begin
          next_r.cnt = r.cnt - CNT_W'(1);
        end
      end

      default: begin
        next_r = RESET_VAL;
      end
    endcase
  end

  // Write strobe lasts SEL_CYC + 1 cycles, address SEL_CYC + 2, reads READ_CYC + 1
  if (SEL_CYC <= FLOAT_CYC) begin : g_chk_float
    $error("write strobe shorter than the output float time");
  end
  if (DATA_CYC > SEL_CYC - FLOAT_CYC + 1) begin : g_chk_dw
    $error("data setup before write end too short");
  end
  if ((SEL_CYC + 1) * CLK_PERIOD_NS < T_SEL_TO_END_NS) begin : g_chk_cw
    $error("select time before write end too short");
  end
  if ((SEL_CYC + 2) * CLK_PERIOD_NS < T_ADDR_TO_END_NS) begin : g_chk_aw
    $error("address time before write end too short");
  end
  if ((READ_CYC + 1) * CLK_PERIOD_NS < T_OE_ACCESS_NS) begin : g_chk_oe
    $error("output strobe window too short");
  end
  if ((READ_CYC + 1) * CLK_PERIOD_NS < T_READ_CYCLE_NS) begin : g_chk_rd
    $error("read window too short");
  end

  // Asynchronous reset returns the pins to the deselected idle state
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      r <= RESET_VAL;
    end else begin
      r <= next_r;
    end
  end

  // Every output is a register field
  assign req_ready = r.req_ready;
  assign rsp_valid = r.rsp_valid;
  assign rsp_rdata = r.rsp_rdata;
  assign retain_ok = r.retain_ok;
  assign address_lines = r.address_lines;
  assign chip_select_low_n = r.chip_select_low_n;
  assign chip_select_high = r.chip_select_high;
  assign output_strobe_n = r.output_strobe_n;
  assign write_strobe_n = r.write_strobe_n;
  assign data_pins_out = r.data_pins_out;
  assign data_pins_oe_n = r.data_pins_oe_n;
endmodule
`default_nettype wire

// ---- verif/asr_sram_model.sv ----
// Behavioural byte-wide static memory on the controller pins
`timescale 1ns/1ns
`default_nettype none
module asr_sram_model #(parameter int ACC = 15) (
  input wire logic [12:0] address_lines,
  input wire logic chip_select_low_n,
  input wire logic chip_select_high,
  input wire logic output_strobe_n,
  input wire logic write_strobe_n,
  input wire logic data_pins_oe_n,
  input wire logic [7:0] data_pins_out,
  output logic [7:0] data_pins_in
);
  logic [7:0] mem [8192];
  logic [7:0] hold = 8'h00;
  wire logic sel = !chip_select_low_n && chip_select_high;
  wire logic wr = sel && !write_strobe_n;
  wire logic rd = sel && !output_strobe_n && write_strobe_n;
  wire logic rd_d;
  // Slow turn-on and turn-off of the outputs
  assign #(ACC) rd_d = rd;
  always @(negedge wr) mem[address_lines] = data_pins_out;
  // Floating pins show the inverse of the last byte
  always @(negedge rd_d) hold = ~mem[address_lines];
  assign data_pins_in = !data_pins_oe_n ? data_pins_out : rd_d ? mem[address_lines] : hold;
endmodule
`default_nettype wire

// ---- verif/asr_ctrl_sva.sv ----
// Pin protocol checks for the memory controller
`timescale 1ns/1ns
`default_nettype none
module asr_ctrl_sva #(parameter int unsigned ADDR_W = 13) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic retain_ok,
  input wire logic [ADDR_W-1:0] address_lines,
  input wire logic chip_select_low_n,
  input wire logic chip_select_high,
  input wire logic output_strobe_n,
  input wire logic write_strobe_n,
  input wire logic data_pins_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_rd; !output_strobe_n |-> write_strobe_n && data_pins_oe_n; endproperty
  a_rd: assert property (p_rd) else $error("strobe clash in read");
  property p_adr; !$stable(address_lines) |-> write_strobe_n && $past(write_strobe_n); endproperty
  a_adr: assert property (p_adr) else $error("address moved in write");
  property p_pol; chip_select_high != chip_select_low_n; endproperty
  a_pol: assert property (p_pol) else $error("select polarity");
  property p_aw; $rose(write_strobe_n) |-> address_lines == $past(address_lines, 10); endproperty
  a_aw: assert property (p_aw) else $error("address setup short");
  property p_dw; $rose(write_strobe_n) |-> !data_pins_oe_n && !$past(data_pins_oe_n, 6); endproperty
  a_dw: assert property (p_dw) else $error("data setup short");
  property p_cw; $rose(write_strobe_n) |-> !chip_select_low_n && !$past(chip_select_low_n, 10);
  endproperty
  a_cw: assert property (p_cw) else $error("select time short");
  property p_ws; $fell(write_strobe_n) |-> $fell(chip_select_low_n); endproperty
  a_ws: assert property (p_ws) else $error("strobe not with select");
  property p_ret; retain_ok |-> chip_select_low_n && $past(chip_select_low_n); endproperty
  a_ret: assert property (p_ret) else $error("retention while selected");
endmodule
bind asr_ctrl asr_ctrl_sva #(.ADDR_W(ADDR_W)) u_sva (.*);
`default_nettype wire

// ---- verif/test_asr_ctrl.sv ----
// Self-checking bench for the memory controller
`timescale 1ns/1ns
`default_nettype none
module test_asr_ctrl import asr_pkg::*;;
  logic clock = 0, sys_rst = 1, req_valid = 0, req_write = 0, retain_req = 0;
  logic [12:0] req_addr = 13'h0000, address_lines;
  logic [7:0] req_wdata = 8'h00, rsp_rdata, data_pins_in, data_pins_out;
  logic req_ready, rsp_valid, retain_ok, chip_select_low_n, chip_select_high;
  logic output_strobe_n, write_strobe_n, data_pins_oe_n;
  int error_cnt = 0, checks = 0, cyc = 0;
  always #5 clock = ~clock;
  asr_ctrl u_dut (.*);
  asr_sram_model u_mem (.*);
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [12:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1) @(negedge clock);
    req_valid = 1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge clock);
    req_valid = 0;
    while (rsp_valid !== 1'b1 && n < 30) begin
      @(negedge clock);
      n++;
    end
    cmp({7'h00, rsp_valid}, 8'h01);
    cmp(8'(n), 8'(wr ? SEL_CYC + 3 : READ_CYC + 2));
  endtask
  task automatic t_edges;
    xfer(1, 13'h0000, 8'ha5);
    xfer(1, 13'h1fff, 8'h5a);
    xfer(0, 13'h0000, 8'h00);
    cmp(rsp_rdata, 8'ha5);
    xfer(0, 13'h1fff, 8'h00);
    cmp(rsp_rdata, 8'h5a);
    $display("edge address test done");
  endtask
  task automatic t_rewrite;
    xfer(1, 13'h0123, 8'hff);
    xfer(1, 13'h0123, 8'h00);
    xfer(0, 13'h0123, 8'hff);
    cmp(rsp_rdata, 8'h00);
    $display("rewrite test done");
  endtask
  task automatic t_retain;
    retain_req = 1;
    repeat (3) @(negedge clock);
    cmp({6'h00, retain_ok, chip_select_low_n}, 8'h03);
    cmp({7'h00, req_ready}, 8'h00);
    retain_req = 0;
    xfer(0, 13'h1fff, 8'h00);
    cmp(rsp_rdata, 8'h5a);
    $display("retention test done");
  endtask
  initial begin
    repeat (10) @(negedge clock);
    sys_rst = 0;
    t_edges;
    t_rewrite;
    t_retain;
    complete_run;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      complete_run;
    end
  end
endmodule
`default_nettype wire
